// ===== verilog/bccf_defines.vh
// Constants shared by the charge control design: offsets, fields, states and timing counts.
`ifndef BCCF_DEFINES_VH
`define BCCF_DEFINES_VH
// Clock and switching periods.
`define BCCF_CLK_PERIOD_NS      40
`define BCCF_SW_FAST_PERIOD_NS  667
`define BCCF_SW_SLOW_PERIOD_NS  1333
`define BCCF_SW_FAST_CYC        (`BCCF_SW_FAST_PERIOD_NS / `BCCF_CLK_PERIOD_NS)
`define BCCF_SW_SLOW_CYC        (`BCCF_SW_SLOW_PERIOD_NS / `BCCF_CLK_PERIOD_NS)
// Regulator counts: dropout and refresh in switching cycles, refresh pulse in reference clock cycles.
`define BCCF_DROPOUT_CYC        8
`define BCCF_REFRESH_CYC        32
`define BCCF_REFRESH_PULSE_CYC  2
// Long timers, prescaled to a one millisecond tick; filter times in reference clock cycles.
`define BCCF_MS_TICK_US         1000
`define BCCF_MS_TICK_CYC        ((`BCCF_MS_TICK_US * 1000) / `BCCF_CLK_PERIOD_NS)
`define BCCF_SAFETY_MIN         120
`define BCCF_SAFETY_MS          (`BCCF_SAFETY_MIN * 60000)
`define BCCF_BADBAT_MIN         30
`define BCCF_BADBAT_MS          (`BCCF_BADBAT_MIN * 60000)
`define BCCF_RECHARGE_THRESHOLD_FILT_US      500
`define BCCF_RECHARGE_THRESHOLD_FILT_CYC     ((`BCCF_RECHARGE_THRESHOLD_FILT_US * 1000 + `BCCF_CLK_PERIOD_NS - 1) / `BCCF_CLK_PERIOD_NS)
`define BCCF_C10_FILT_US        350
`define BCCF_C10_FILT_CYC       ((`BCCF_C10_FILT_US * 1000) / `BCCF_CLK_PERIOD_NS + 1)
// Register byte offsets.
`define BCCF_OFS_CTRL           8'h00
`define BCCF_OFS_STATUS         8'h04
`define BCCF_OFS_EVENT          8'h08
`define BCCF_OFS_SAFETY         8'h0c
`define BCCF_OFS_BADBAT         8'h10
// Control fields and reset value.
`define BCCF_CTRL_ENABLE        0
`define BCCF_CTRL_RESTART       1
`define BCCF_CTRL_NTC_IGNORE    2
`define BCCF_CTRL_RESET         3'h1
// Event fields.
`define BCCF_EV_TERM            0
`define BCCF_EV_BADBAT          1
`define BCCF_EV_RECHARGE_THRESHOLD           2
`define BCCF_EV_PAUSE           3
// Charger states.
`define BCCF_ST_DISABLED        3'h0
`define BCCF_ST_SHUTDOWN        3'h1
`define BCCF_ST_PRECOND         3'h2
`define BCCF_ST_TRICKLE         3'h3
`define BCCF_ST_CHARGE          3'h4
`define BCCF_ST_SLEEP           3'h5
`define BCCF_ST_BADBAT          3'h6
`define BCCF_ST_PAUSE           3'h7
`endif

// ===== verilog/bccf_sync.v
// Two-stage synchroniser for a vector of comparator decisions.
`timescale 1ns/10ps
module bccf_sync #(
   parameter WIDTH = 1
) (
   // Clock, reset and enable.
   input  wire             ref_clk_i,
   input  wire             srst_i,
   input  wire             ce_i,
   // Data.
   input  wire [WIDTH-1:0] async_i,
   output wire [WIDTH-1:0] sync_o
);
   genvar g;
   // Each bit gets its own pair of flops; only the second stage is visible.
   generate
      for (g = 0; g < WIDTH; g = g + 1) begin : g_bit
         reg meta_q;
         reg sync_q;
         always @(posedge ref_clk_i) begin
            if (srst_i) begin
               meta_q <= 1'b0;
               sync_q <= 1'b0;
            end else if (ce_i) begin
               meta_q <= async_i[g];
               sync_q <= meta_q;
            end
         end
         assign sync_o[g] = sync_q;
      end
   endgenerate
endmodule // bccf_sync

// ===== verilog/bccf_pwm_guard.v
// Switch drive with dropout limit and flying-capacitor refresh.
`timescale 1ns/10ps
`include "bccf_defines.vh"
module bccf_pwm_guard #(
   parameter DROPOUT_CYC = `BCCF_DROPOUT_CYC,
   parameter REFRESH_CYC = `BCCF_REFRESH_CYC,
   parameter PULSE_CYC   = `BCCF_REFRESH_PULSE_CYC
) (
   // Clock, reset and enable.
   input  wire ref_clk_i,
   input  wire srst_i,
   input  wire ce_i,
   // Control from the charger.
   input  wire sw_tick_i,
   input  wire en_i,
   input  wire top_req_i,
   input  wire izero_i,
   // Switch drive.
   output reg  hs_on_o,
   output reg  ls_on_o
);
   reg  [3:0] on_cnt_q;
   reg  [5:0] ref_cnt_q;
   reg  [1:0] pulse_q;
   reg        drop_q;
   wire       force_ls = drop_q | (pulse_q != 2'h0);
   wire       hs_d     = en_i & top_req_i & ~force_ls;
   wire       ls_d     = en_i & (force_ls | (~top_req_i & ~izero_i));

   // Cycle counters and forced low-side windows.
   always @(posedge ref_clk_i) begin
      if (srst_i) begin
         on_cnt_q  <= 4'h0;
         ref_cnt_q <= 6'h0;
         pulse_q   <= 2'h0;
         drop_q    <= 1'b0;
         hs_on_o   <= 1'b0;
         ls_on_o   <= 1'b0;
      end else if (ce_i) begin
         hs_on_o <= hs_d;
         ls_on_o <= ls_d;
         if (sw_tick_i) begin
            if (hs_on_o && !force_ls)
               on_cnt_q <= (on_cnt_q == DROPOUT_CYC[3:0]) ? on_cnt_q : on_cnt_q + 4'h1;
            else
               on_cnt_q <= 4'h0;
         end
         // Forcing the bottom switch stops audible noise and keeps the boost capacitor charged.
         if (sw_tick_i && hs_on_o && on_cnt_q == DROPOUT_CYC[3:0] - 4'h1) begin
            drop_q   <= 1'b1;
            on_cnt_q <= 4'h0;
         end else if (sw_tick_i || izero_i) begin
            drop_q <= 1'b0;
         end
         // Any low-side turn-on recharges the flying capacitor.
         if (ls_d && !ls_on_o) begin
            ref_cnt_q <= 6'h0;
         end else if (sw_tick_i && ref_cnt_q != REFRESH_CYC[5:0]) begin
            ref_cnt_q <= ref_cnt_q + 6'h1;
         end
         if (sw_tick_i && ref_cnt_q == REFRESH_CYC[5:0] && en_i)
            pulse_q <= PULSE_CYC[1:0];
         else if (pulse_q != 2'h0)
            pulse_q <= pulse_q - 2'h1;
      end
   end
endmodule // bccf_pwm_guard

// ===== verilog/bccf_top.v
// Battery charge control sequencer with APB registers and status pins.
//
// Local design decisions: the APB register port and the register offsets.
`timescale 1ns/10ps
`include "bccf_defines.vh"
module bccf_top #(
   parameter        MS_TICK_CYC    = `BCCF_MS_TICK_CYC,
   parameter [23:0] SAFETY_MS      = `BCCF_SAFETY_MS,
   parameter [23:0] BADBAT_MS      = `BCCF_BADBAT_MS,
   parameter [15:0] RECHARGE_THRESHOLD_FILT_CYC = `BCCF_RECHARGE_THRESHOLD_FILT_CYC,
   parameter [15:0] C10_FILT_CYC   = `BCCF_C10_FILT_CYC
) (
   // Clock, reset and enable.
   input  wire        ref_clk_i,
   input  wire        srst_i,
   input  wire        ce_i,
   // APB slave.
   input  wire        psel_i,
   input  wire        penable_i,
   input  wire        pwrite_i,
   input  wire [7:0]  paddr_i,
   input  wire [31:0] pwdata_i,
   output reg  [31:0] prdata_o,
   output wire        pready_o,
   output wire        pslverr_o,
   // Comparator decisions.
   input  wire        run_en_i,
   input  wire        run_above_sd_i,
   input  wire        duvlo_ok_i,
   input  wire        above_lowbat_i,
   input  wire        above_trickle_i,
   input  wire        at_float_i,
   input  wire        below_recharge_i,
   input  wire        cc_mode_i,
   input  wire        current_monitor_low_i,
   input  wire        therm_hot_i,
   input  wire        therm_cold_i,
   input  wire        therm_disable_i,
   input  wire        batt_present_i,
   input  wire        frequency_select_i,
   input  wire        below_80ma_i,
   input  wire        above_150ma_i,
   input  wire        izero_i,
   input  wire        top_req_i,
   // Open-drain status and ground return pins.
   input  wire        charge_status_n_i,
   output wire        charge_status_n_o,
   output reg         charge_status_oe_n_o,
   input  wire        fault_n_i,
   output wire        fault_n_o,
   output reg         fault_oe_n_o,
   output wire        feedback_ground_return_o,
   output reg         feedback_ground_return_oe_n_o,
   // Power stage controls.
   output reg         precondition_current_en_o,
   output reg         regulator_en_o,
   output reg         trickle_level_o,
   output reg         full_scale_o,
   output reg         burst_standby_o,
   output reg         shutdown_o,
   output wire        hs_on_o,
   output wire        ls_on_o
);
   // Synchronised comparator bits.
   wire [19:0] s;
   bccf_sync #(.WIDTH(20)) u_sync (
      .ref_clk_i (ref_clk_i),
      .srst_i    (srst_i),
      .ce_i      (ce_i),
      .async_i   ({fault_n_i, charge_status_n_i, top_req_i, izero_i, above_150ma_i, below_80ma_i,
                   frequency_select_i, batt_present_i, therm_disable_i, therm_cold_i, therm_hot_i,
                   current_monitor_low_i, cc_mode_i, below_recharge_i, at_float_i, above_trickle_i,
                   above_lowbat_i, duvlo_ok_i, run_above_sd_i, run_en_i}),
      .sync_o    (s)
   );
   wire s_run = s[0];
   wire s_sd_ok = s[1];
   wire s_duvlo = s[2];
   wire s_lowbat = s[3];
   wire s_trkl = s[4];
   wire s_float = s[5];
   wire s_rchg = s[6];
   wire s_cc = s[7];
   wire s_current_monitor = s[8];
   wire s_hot = s[9];
   wire s_cold = s[10];
   wire s_ndis = s[11];
   wire s_batt = s[12];
   wire s_frequency_select = s[13];
   wire s_lo80 = s[14];
   wire s_hi150 = s[15];
   wire s_izero = s[16];
   wire s_top = s[17];
   wire s_charge_status_n_pin = s[18];
   wire s_fault_pin = s[19];

   reg  [2:0]  state_q;
   reg  [2:0]  state_d;
   reg  [2:0]  resume_q;
   reg  [2:0]  ctrl_q;
   reg  [3:0]  ev_q;
   reg  [15:0] ms_cnt_q;
   reg  [5:0]  sw_cnt_q;
   reg  [23:0] safety_q;
   reg  [23:0] badbat_q;
   reg  [15:0] rf_cnt_q;
   reg  [15:0] c10_cnt_q;
   reg         c10_q;
   reg         float_q;
   reg         rchg_prev_q;
   reg         cc_seen_q;
   reg         batt_gone_q;

   // Prescaled tick and switching tick.
   wire ms_tick = (ms_cnt_q == MS_TICK_CYC[15:0] - 16'h1);
   // Periods are whole reference cycles, so the switching rate runs slightly fast of nominal.
   localparam [31:0] SW_FAST_CYC = `BCCF_SW_FAST_CYC;
   localparam [31:0] SW_SLOW_CYC = `BCCF_SW_SLOW_CYC;
   wire [5:0] sw_div = s_frequency_select ? SW_FAST_CYC[5:0] : SW_SLOW_CYC[5:0];
   wire sw_tick = (sw_cnt_q == sw_div - 6'h1);

   // Decoded conditions.
   wire therm_fault = (s_hot | s_cold) & ~s_ndis & ~ctrl_q[`BCCF_CTRL_NTC_IGNORE];
   wire charging = (state_q == `BCCF_ST_PRECOND) | (state_q == `BCCF_ST_TRICKLE) |
                   (state_q == `BCCF_ST_CHARGE);
   wire safety_done = float_q & ms_tick & ~s_cc & (safety_q == SAFETY_MS - 24'h1);
   wire badbat_done = ms_tick & (badbat_q == BADBAT_MS - 24'h1);
   wire rchg_cross = s_rchg ^ rchg_prev_q;
   wire rchg_start = (state_q == `BCCF_ST_SLEEP) & (rf_cnt_q == RECHARGE_THRESHOLD_FILT_CYC - 16'h1);
   wire reinsert = (state_q == `BCCF_ST_BADBAT) & batt_gone_q & s_batt;
   wire wr_en = psel_i & penable_i & pwrite_i & ce_i;
   wire restart = wr_en & (paddr_i == `BCCF_OFS_CTRL) & pwdata_i[`BCCF_CTRL_RESTART];
   wire enabled = s_run & ctrl_q[`BCCF_CTRL_ENABLE];
   wire start_cyc = (state_d == `BCCF_ST_PRECOND) & ~charging & (state_q != `BCCF_ST_PAUSE);

   // Next-state logic; lockout and run have priority over every charge state.
   always @* begin
      state_d = state_q;
      if (!s_duvlo || !s_sd_ok) begin
         state_d = `BCCF_ST_SHUTDOWN;
      end else if (!enabled) begin
         state_d = `BCCF_ST_DISABLED;
      end else if (restart) begin
         state_d = `BCCF_ST_PRECOND;
      end else begin
         case (state_q)
            `BCCF_ST_DISABLED,
            `BCCF_ST_SHUTDOWN: begin
               state_d = `BCCF_ST_PRECOND;
            end
            `BCCF_ST_PRECOND: begin
               if (therm_fault)
                  state_d = `BCCF_ST_PAUSE;
               else if (badbat_done)
                  state_d = `BCCF_ST_BADBAT;
               else if (s_lowbat)
                  state_d = `BCCF_ST_TRICKLE;
            end
            `BCCF_ST_TRICKLE: begin
               if (therm_fault)
                  state_d = `BCCF_ST_PAUSE;
               else if (badbat_done)
                  state_d = `BCCF_ST_BADBAT;
               else if (s_trkl)
                  state_d = `BCCF_ST_CHARGE;
               else if (!s_lowbat)
                  state_d = `BCCF_ST_PRECOND;
            end
            `BCCF_ST_CHARGE: begin
               if (therm_fault)
                  state_d = `BCCF_ST_PAUSE;
               else if (safety_done)
                  state_d = `BCCF_ST_SLEEP;
            end
            `BCCF_ST_PAUSE: begin
               if (!therm_fault)
                  state_d = resume_q;
            end
            `BCCF_ST_SLEEP: begin
               if (rchg_start)
                  state_d = `BCCF_ST_PRECOND;
            end
            `BCCF_ST_BADBAT: begin
               if (reinsert)
                  state_d = `BCCF_ST_PRECOND;
            end
            default: begin
               state_d = `BCCF_ST_DISABLED;
            end
         endcase
      end
   end

   // Sequencer state, timers and filters; everything freezes while ce_i is low.
   always @(posedge ref_clk_i) begin
      if (srst_i) begin
         state_q     <= `BCCF_ST_DISABLED;
         resume_q    <= `BCCF_ST_PRECOND;
         ms_cnt_q    <= 16'h0;
         sw_cnt_q    <= 6'h0;
         safety_q    <= 24'h0;
         badbat_q    <= 24'h0;
         rf_cnt_q    <= 16'h0;
         c10_cnt_q   <= 16'h0;
         c10_q       <= 1'b0;
         float_q     <= 1'b0;
         rchg_prev_q <= 1'b0;
         cc_seen_q   <= 1'b0;
         batt_gone_q <= 1'b0;
      end else if (ce_i) begin
         state_q     <= state_d;
         rchg_prev_q <= s_rchg;
         ms_cnt_q    <= ms_tick ? 16'h0 : ms_cnt_q + 16'h1;
         sw_cnt_q    <= sw_tick ? 6'h0 : sw_cnt_q + 6'h1;
         if (charging)
            resume_q <= state_q;
         // Safety timer.
         if (start_cyc || rchg_cross) begin
            safety_q <= 24'h0;
            float_q  <= 1'b0;
         end else if (state_q == `BCCF_ST_CHARGE) begin
            if (s_float)
               float_q <= 1'b1;
            if (float_q && ms_tick && !s_cc)
               safety_q <= safety_done ? 24'h0 : safety_q + 24'h1;
         end
         // Bad-battery timer runs only while below the trickle threshold.
         if (start_cyc)
            badbat_q <= 24'h0;
         else if ((state_q == `BCCF_ST_PRECOND || state_q == `BCCF_ST_TRICKLE) && ms_tick)
            badbat_q <= badbat_q + 24'h1;
         // Recharge filter rejects short load transients.
         if (state_q == `BCCF_ST_SLEEP && s_rchg && !rchg_start)
            rf_cnt_q <= rf_cnt_q + 16'h1;
         else
            rf_cnt_q <= 16'h0;
         // C/10 filter; once passed it stays latched so burst gaps cannot flicker the pin.
         if (start_cyc) begin
            c10_q     <= 1'b0;
            c10_cnt_q <= 16'h0;
         end else if (state_q == `BCCF_ST_CHARGE && s_current_monitor) begin
            if (c10_cnt_q == C10_FILT_CYC - 16'h1)
               c10_q <= 1'b1;
            else
               c10_cnt_q <= c10_cnt_q + 16'h1;
         end else begin
            c10_cnt_q <= 16'h0;
         end
         // Constant-current history for burst entry.
         if (state_q != `BCCF_ST_CHARGE)
            cc_seen_q <= 1'b0;
         else if (s_cc)
            cc_seen_q <= 1'b1;
         // Battery removal tracking.
         if (state_q != `BCCF_ST_BADBAT)
            batt_gone_q <= 1'b0;
         else if (!s_batt)
            batt_gone_q <= 1'b1;
      end
   end

   // Pin and power-stage outputs, registered from the current state.
   always @(posedge ref_clk_i) begin
      if (srst_i) begin
         charge_status_oe_n_o          <= 1'b1;
         fault_oe_n_o                  <= 1'b1;
         feedback_ground_return_oe_n_o <= 1'b1;
         precondition_current_en_o     <= 1'b0;
         regulator_en_o                <= 1'b0;
         trickle_level_o               <= 1'b0;
         full_scale_o                  <= 1'b0;
         burst_standby_o               <= 1'b0;
         shutdown_o                    <= 1'b1;
      end else if (ce_i) begin
         charge_status_oe_n_o <= ~(((state_q == `BCCF_ST_PRECOND) | (state_q == `BCCF_ST_TRICKLE) |
                                    ((state_q == `BCCF_ST_CHARGE) & ~c10_q)) |
                                   (state_q == `BCCF_ST_PAUSE));
         fault_oe_n_o <= ~((state_q == `BCCF_ST_BADBAT) | (state_q == `BCCF_ST_PAUSE));
         feedback_ground_return_oe_n_o <= (state_q == `BCCF_ST_DISABLED) |
                                          (state_q == `BCCF_ST_SHUTDOWN);
         precondition_current_en_o <= (state_q == `BCCF_ST_PRECOND) |
                                      (state_q == `BCCF_ST_TRICKLE);
         regulator_en_o  <= (state_q == `BCCF_ST_TRICKLE) | (state_q == `BCCF_ST_CHARGE);
         trickle_level_o <= (state_q == `BCCF_ST_TRICKLE);
         full_scale_o    <= (state_q == `BCCF_ST_CHARGE);
         if (state_q != `BCCF_ST_CHARGE || s_hi150)
            burst_standby_o <= 1'b0;
         else if (cc_seen_q && !s_cc && s_lo80)
            burst_standby_o <= 1'b1;
         shutdown_o <= (state_q == `BCCF_ST_SHUTDOWN);
      end
   end
   assign charge_status_n_o        = 1'b0;
   assign fault_n_o                = 1'b0;
   assign feedback_ground_return_o = 1'b0;

   // Switch drive; in standby the top request is suppressed between bursts.
   bccf_pwm_guard u_pwm (
      .ref_clk_i (ref_clk_i),
      .srst_i    (srst_i),
      .ce_i      (ce_i),
      .sw_tick_i (sw_tick),
      .en_i      (regulator_en_o),
      .top_req_i (s_top & ~(burst_standby_o & s_izero)),
      .izero_i   (s_izero),
      .hs_on_o   (hs_on_o),
      .ls_on_o   (ls_on_o)
   );

   // Control and event registers; a hardware event wins over a clear in the same cycle.
   wire [3:0] ev_set = {(state_q != `BCCF_ST_PAUSE) & (state_d == `BCCF_ST_PAUSE),
                        rchg_start, (state_q != `BCCF_ST_BADBAT) & (state_d == `BCCF_ST_BADBAT),
                        safety_done & (state_q == `BCCF_ST_CHARGE)};
   wire [3:0] ev_clr = (wr_en && paddr_i == `BCCF_OFS_EVENT) ? pwdata_i[3:0] : 4'h0;
   always @(posedge ref_clk_i) begin
      if (srst_i) begin
         ctrl_q <= `BCCF_CTRL_RESET;
         ev_q   <= 4'h0;
      end else if (ce_i) begin
         if (wr_en && paddr_i == `BCCF_OFS_CTRL)
            ctrl_q <= {pwdata_i[`BCCF_CTRL_NTC_IGNORE], 1'b0, pwdata_i[`BCCF_CTRL_ENABLE]};
         ev_q <= (ev_q & ~ev_clr) | ev_set;
      end
   end

   // Read data is captured in the setup cycle and stands through the access phase.
   always @(posedge ref_clk_i) begin
      if (srst_i) begin
         prdata_o <= 32'h0;
      end else if (ce_i && psel_i && !penable_i) begin
         case (paddr_i)
            `BCCF_OFS_CTRL:   prdata_o <= {29'h0, ctrl_q};
            `BCCF_OFS_STATUS: prdata_o <= {22'h0, s_cc, s_fault_pin, s_charge_status_n_pin, therm_fault,
                                           burst_standby_o, c10_q, float_q, state_q};
            `BCCF_OFS_EVENT:  prdata_o <= {28'h0, ev_q};
            `BCCF_OFS_SAFETY: prdata_o <= {8'h0, safety_q};
            `BCCF_OFS_BADBAT: prdata_o <= {8'h0, badbat_q};
            default:          prdata_o <= 32'h0;
         endcase
      end
   end
   assign pready_o  = ce_i;
   assign pslverr_o = psel_i & penable_i & (paddr_i != `BCCF_OFS_CTRL) & (paddr_i != `BCCF_OFS_STATUS) &
                      (paddr_i != `BCCF_OFS_EVENT) & (paddr_i != `BCCF_OFS_SAFETY) &
                      (paddr_i != `BCCF_OFS_BADBAT);
endmodule // bccf_top

// ===== tb/bccf_properties.sv
// Port checker for the charge control sequencer.
`timescale 1ns/10ps
module bccf_properties (
   // Clock, reset and enable.
   input wire logic ref_clk_i, srst_i, ce_i,
   // Pins and power stage.
   input wire logic charge_status_oe_n_o, fault_oe_n_o, feedback_ground_return_oe_n_o, shutdown_o,
   input wire logic precondition_current_en_o, regulator_en_o, trickle_level_o, full_scale_o, hs_on_o
);
   logic [8:0] hs_run_q;
   default clocking @(posedge ref_clk_i); endclocking
   default disable iff (srst_i);
   // Length of the present top switch run; it saturates so a stuck switch cannot wrap back to a small count.
   always @(posedge ref_clk_i) begin
      hs_run_q <= (srst_i || !hs_on_o) ? 9'h0 : hs_run_q + {8'h0, ~&hs_run_q};
   end
   dropout_cut_a: assert property (hs_run_q < 9'h12c) else $error("top switch run too long");
   reset_released_a: assert property ($fell(srst_i) |-> shutdown_o && charge_status_oe_n_o && fault_oe_n_o)
      else $error("pins not released after reset");
   shutdown_pins_a: assert property (shutdown_o |-> charge_status_oe_n_o && fault_oe_n_o
      && feedback_ground_return_oe_n_o) else $error("pin driven in shutdown");
   trickle_adds_dc_a: assert property (trickle_level_o |-> regulator_en_o && precondition_current_en_o)
      else $error("trickle without dc current");
   full_drops_dc_a: assert property (full_scale_o |-> !precondition_current_en_o && !trickle_level_o)
      else $error("dc current with full scale");
   pause_stops_a: assert property (!charge_status_oe_n_o && !fault_oe_n_o |-> !regulator_en_o)
      else $error("charging during pause");
   badbat_stops_a: assert property (charge_status_oe_n_o && !fault_oe_n_o |-> !regulator_en_o
      && !precondition_current_en_o) else $error("charging after bad battery");
   freeze_a: assert property (!ce_i |=> $stable(hs_on_o) && $stable(shutdown_o))
      else $error("state moved while frozen");
endmodule // bccf_properties

// ===== tb/bccf_partner.sv
// Pull-up model for the two open-drain status pins.
`timescale 1ns/10ps
module bccf_partner (
   input  wire logic [1:0] oe_n_i, // Pin enables, low pulls the pin down.
   output wire logic [1:0] pin_o
);
   // A released pin reads high through its resistor, never the last driven level.
   assign pin_o = oe_n_i;
endmodule // bccf_partner

// ===== tb/bccf_top_bench.sv
// Self-checking bench for the charge control sequencer.
`timescale 1ns/10ps
module bccf_top_bench;
   logic clk = 1'b0, srst = 1'b1, ce = 1'b1, psel = 1'b0, pen = 1'b0, pwr = 1'b0, er, cs_oe_n, ft_oe_n, fg_oe_n;
   logic [7:0] pa = 8'h00;
   logic [31:0] pwd = 32'h0, prd, rv;
   logic [17:0] ana = 18'h0; // Comparator decisions in port order.
   wire [5:0] pw;
   wire [1:0] pin;
   wire pready, perr, hs, ls;
   int error_cnt = 0, cmp_count = 0, cyc = 0;
   bccf_top #(.MS_TICK_CYC(10), .SAFETY_MS(24'd20), .BADBAT_MS(24'd10), .RECHARGE_THRESHOLD_FILT_CYC(16'd8), .C10_FILT_CYC(16'd8))
   u_dut (.ref_clk_i(clk), .srst_i(srst), .ce_i(ce), .psel_i(psel), .penable_i(pen), .pwrite_i(pwr), .paddr_i(pa),
      .pwdata_i(pwd), .prdata_o(prd), .pready_o(pready), .pslverr_o(perr), .run_en_i(ana[0]), .run_above_sd_i(ana[1]),
      .duvlo_ok_i(ana[2]), .above_lowbat_i(ana[3]), .above_trickle_i(ana[4]), .at_float_i(ana[5]),
      .below_recharge_i(ana[6]), .cc_mode_i(ana[7]), .current_monitor_low_i(ana[8]), .therm_hot_i(ana[9]), .therm_cold_i(ana[10]),
      .therm_disable_i(ana[11]), .batt_present_i(ana[12]), .frequency_select_i(ana[13]), .below_80ma_i(ana[14]),
      .above_150ma_i(ana[15]), .izero_i(ana[16]), .top_req_i(ana[17]), .charge_status_n_i(pin[0]),
      .charge_status_n_o(), .charge_status_oe_n_o(cs_oe_n), .fault_n_i(pin[1]), .fault_n_o(), .fault_oe_n_o(ft_oe_n),
      .feedback_ground_return_o(), .feedback_ground_return_oe_n_o(fg_oe_n), .precondition_current_en_o(pw[0]),
      .regulator_en_o(pw[1]), .trickle_level_o(pw[2]), .full_scale_o(pw[3]), .burst_standby_o(pw[4]),
      .shutdown_o(pw[5]), .hs_on_o(hs), .ls_on_o(ls));
   bccf_partner u_pin (.oe_n_i({ft_oe_n, cs_oe_n}), .pin_o(pin));
   // Clock at 25 MHz.
   initial forever #20 clk = ~clk;
   // Compare and count.
   task chk(input string n, input logic [31:0] g, e);
      cmp_count++;
      if (g !== e) begin
         error_cnt++;
         $display("ERROR %s expected %h seen %h", n, e, g);
      end
   endtask
   task end_sim;
      $display("compares %0d mismatches %0d", cmp_count, error_cnt);
      if (error_cnt == 0 && cmp_count > 0) $display("verification passed");
      else $display("verification failed");
      $finish;
   endtask
   // One APB transfer; an idle edge follows so back-to-back calls never assign psel twice in one step.
   task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      psel <= 1'b1;
      pwr <= w;
      pa <= a;
      pwd <= d;
      @(posedge clk) pen <= 1'b1;
      @(posedge clk);
      while (pready !== 1'b1) @(posedge clk);
      rv = prd;
      er = perr;
      psel <= 1'b0;
      pen <= 1'b0;
      @(posedge clk);
   endtask
   // Poll the state field until it matches or the poll budget is spent.
   task st(input logic [2:0] e, input int n);
      apb(1'b0, 8'h04, 32'h0);
      repeat (n) if (rv[2:0] !== e) apb(1'b0, 8'h04, 32'h0);
      chk("state", rv[2:0], e);
   endtask
   // Cycle ceiling well above the longest sequence.
   always @(posedge clk) begin
      cyc <= cyc + 1;
      if (cyc == 20000) begin
         error_cnt++;
         end_sim;
      end
   end
   initial begin
      repeat (5) @(posedge clk);
      srst <= 1'b0;
      ana <= 18'h1007;
      apb(1'b0, 8'h00, 32'h0);
      chk("ctrl", rv, 32'h1);
      apb(1'b0, 8'h20, 32'h0);
      chk("unmapped", {rv[30:0], er}, 32'h1);
      st(3'h2, 20);
      chk("dc only", {cs_oe_n, pw[2:0]}, 32'h1);
      st(3'h6, 60);
      chk("bad pins", {cs_oe_n, ft_oe_n, pw[1:0]}, 32'h8);
      ana[12] <= 1'b0;
      repeat (4) @(posedge clk);
      ana[12] <= 1'b1;
      st(3'h2, 20);
      ana[3] <= 1'b1;
      st(3'h3, 20);
      chk("trickle", pw[2:0], 32'h7);
      // Above trickle, at float, constant current, battery present, top switch requested.
      ana[17:4] <= 14'h210b;
      st(3'h4, 20);
      chk("full", {pw[3], pw[0], cs_oe_n}, 32'h4);
      repeat (300) @(posedge clk);
      st(3'h4, 0);
      apb(1'b0, 8'h0c, 32'h0);
      chk("safety held", rv, 32'h0);
      ana[9] <= 1'b1;
      st(3'h7, 20);
      chk("pause pins", {cs_oe_n, ft_oe_n}, 32'h0);
      apb(1'b0, 8'h04, 32'h0);
      chk("pause readback", rv[8:7], 32'h0);
      ana[11] <= 1'b1;
      st(3'h4, 20);
      ana[11:7] <= 5'h00;
      ana[14] <= 1'b1;
      repeat (6) @(posedge clk);
      chk("burst on", pw[4], 32'h1);
      ana[15] <= 1'b1;
      repeat (6) @(posedge clk);
      chk("burst off", pw[4], 32'h0);
      // A feedback pulse late in the timeout restarts it, so charging must outlast the first expiry.
      repeat (140) @(posedge clk);
      ana[6] <= 1'b1;
      repeat (4) @(posedge clk);
      ana[6] <= 1'b0;
      repeat (100) @(posedge clk);
      st(3'h4, 0);
      st(3'h5, 120);
      chk("sleep pins", {cs_oe_n, ft_oe_n, pw[1]}, 32'h6);
      ana[6] <= 1'b1;
      repeat (4) @(posedge clk);
      ana[6] <= 1'b0;
      repeat (20) @(posedge clk);
      st(3'h5, 0);
      ana[6] <= 1'b1;
      st(3'h4, 20);
      apb(1'b0, 8'h08, 32'h0);
      chk("events", rv, 32'hf);
      apb(1'b1, 8'h08, 32'hf);
      apb(1'b0, 8'h08, 32'h0);
      chk("events cleared", rv, 32'h0);
      ana[8] <= 1'b1;
      repeat (16) @(posedge clk);
      chk("c10 release", cs_oe_n, 32'h1);
      st(3'h4, 0);
      ce <= 1'b0;
      repeat (3) @(posedge clk);
      ce <= 1'b1;
      ana[2] <= 1'b0;
      st(3'h1, 20);
      chk("shutdown", pw[5], 32'h1);
      ana[2:0] <= 3'h6;
      st(3'h0, 20);
      chk("off pins", {fg_oe_n, cs_oe_n, ft_oe_n}, 32'h7);
      apb(1'b0, 8'h04, 32'h0);
      chk("off readback", rv[8:7], 32'h3);
      end_sim;
   end
endmodule // bccf_top_bench
bind bccf_top bccf_properties u_chk (.*);
